// File: design/asf_alu_flags.sv
// ALU with arithmetic status flags and status-register write-back
`timescale 1ns/1ps
`default_nettype none
module asf_alu_flags (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire asf_pkg::asf_op_t i_op,
  input wire asf_pkg::asf_amode_t i_amode,
  input wire logic i_extended_set_enable,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_operand,
  input wire logic [11:0] i_dest_addr,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_rd_data,
  output logic [7:0] o_result,
  output logic o_result_we,
  output logic [11:0] o_result_addr,
  output logic [7:0] o_alu_flags,
  output logic o_amode_err
);
  logic [7:0] alu_flags_reg;
  logic [7:0] result_reg;
  logic result_we_reg;
  logic [11:0] result_addr_reg;
  logic amode_err_reg;

  logic [7:0] res_next;
  logic [7:0] flags_next;
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic arith;
  logic logic_op;
  logic rot;
  logic flag_op;
  logic shifted_out;
  logic amode_ok;
  logic to_status;
  logic [7:0] cur_status;

  // Rotate carry-in and flag base read the live register, upper bits zero
  assign cur_status = alu_flags_reg & asf_pkg::ASF_IMPL_MASK;
  assign to_status = (i_dest_addr == asf_pkg::ASF_STATUS_ADDR);

  // Indexed mode is illegal while the extended set is off
  always_comb begin
    unique case (i_amode)
      asf_pkg::ASF_AM_INHERENT, asf_pkg::ASF_AM_LITERAL,
      asf_pkg::ASF_AM_DIRECT, asf_pkg::ASF_AM_INDIRECT: amode_ok = 1'b1;
      asf_pkg::ASF_AM_INDEXED: amode_ok = i_extended_set_enable;
      default: amode_ok = 1'b0;
    endcase
  end

  // Subtraction as add of complement with carry-in one
  always_comb begin
    opa = i_operand;
    opb = i_acc;
    cin = 1'b0;
    unique case (i_op)
      asf_pkg::ASF_OP_SUB_FROM_LITERAL: begin
        opa = i_operand;
        opb = ~i_acc;
        cin = 1'b1;
      end
      asf_pkg::ASF_OP_SUB_ACC_FROM_FILE: begin
        opa = i_operand;
        opb = ~i_acc;
        cin = 1'b1;
      end
      default: begin
        opa = i_operand;
        opb = i_acc;
        cin = 1'b0;
      end
    endcase
  end

  assign sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  assign sum5 = {1'b0, opa[asf_pkg::ASF_NIB-1:0]} + {1'b0, opb[asf_pkg::ASF_NIB-1:0]} + {4'h0, cin};

  // Op class decode: which flags an op may touch
  always_comb begin
    arith = 1'b0;
    logic_op = 1'b0;
    rot = 1'b0;
    unique case (i_op)
      asf_pkg::ASF_OP_ADD_ACC_FILE, asf_pkg::ASF_OP_ADD_LITERAL,
      asf_pkg::ASF_OP_SUB_FROM_LITERAL, asf_pkg::ASF_OP_SUB_ACC_FROM_FILE:
        arith = 1'b1;
      asf_pkg::ASF_OP_AND, asf_pkg::ASF_OP_OR, asf_pkg::ASF_OP_XOR,
      asf_pkg::ASF_OP_CLEAR_FILE:
        logic_op = 1'b1;
      asf_pkg::ASF_OP_ROTATE_LEFT, asf_pkg::ASF_OP_ROTATE_RIGHT:
        rot = 1'b1;
      default: begin
        arith = 1'b0;
        logic_op = 1'b0;
        rot = 1'b0;
      end
    endcase
  end

  // Any flag-changing op; into status these discard the data
  assign flag_op = arith || logic_op || rot;
  assign shifted_out = (i_op == asf_pkg::ASF_OP_ROTATE_LEFT) ?
                       i_operand[asf_pkg::ASF_MSB] : i_operand[asf_pkg::ASF_C_BIT];

  // Result datapath
  always_comb begin
    res_next = i_operand;
    unique case (i_op)
      asf_pkg::ASF_OP_ADD_ACC_FILE, asf_pkg::ASF_OP_ADD_LITERAL,
      asf_pkg::ASF_OP_SUB_FROM_LITERAL, asf_pkg::ASF_OP_SUB_ACC_FROM_FILE:
        res_next = sum9[7:0];
      asf_pkg::ASF_OP_ROTATE_LEFT:
        res_next = {i_operand[6:0], cur_status[asf_pkg::ASF_C_BIT]};
      asf_pkg::ASF_OP_ROTATE_RIGHT:
        res_next = {cur_status[asf_pkg::ASF_C_BIT], i_operand[7:1]};
      asf_pkg::ASF_OP_CLEAR_FILE: res_next = asf_pkg::ASF_ZERO;
      asf_pkg::ASF_OP_AND: res_next = i_operand & i_acc;
      asf_pkg::ASF_OP_OR: res_next = i_operand | i_acc;
      asf_pkg::ASF_OP_XOR: res_next = i_operand ^ i_acc;
      asf_pkg::ASF_OP_BIT_CLEAR:
        res_next = i_operand & ~(asf_pkg::ASF_ONE << i_bit_sel);
      asf_pkg::ASF_OP_BIT_SET:
        res_next = i_operand | (asf_pkg::ASF_ONE << i_bit_sel);
      asf_pkg::ASF_OP_NIBBLE_SWAP: res_next = {i_operand[3:0], i_operand[7:4]};
      asf_pkg::ASF_OP_MOVE: res_next = i_operand;
      default: res_next = i_operand;
    endcase
  end

  // Flag derivation; non-flag ops into files other than status leave it as it stands
  always_comb begin
    flags_next = cur_status;
    if (flag_op) begin
      flags_next[asf_pkg::ASF_N_BIT] = res_next[asf_pkg::ASF_MSB];
      flags_next[asf_pkg::ASF_Z_BIT] = (res_next == asf_pkg::ASF_ZERO);
    end
    if (arith) begin
      flags_next[asf_pkg::ASF_OV_BIT] =
        (opa[asf_pkg::ASF_MSB] == opb[asf_pkg::ASF_MSB]) &&
        (sum9[asf_pkg::ASF_MSB] != opa[asf_pkg::ASF_MSB]);
      flags_next[asf_pkg::ASF_DC_BIT] = sum5[asf_pkg::ASF_NIB];
      flags_next[asf_pkg::ASF_C_BIT] = sum9[asf_pkg::ASF_W];
    end else if (logic_op) begin
      flags_next[asf_pkg::ASF_OV_BIT] = 1'b0;
    end
    if (rot) begin
      flags_next[asf_pkg::ASF_C_BIT] = shifted_out;
    end
    // Clear of any file changes Z alone: N stays unchanged too
    if (i_op == asf_pkg::ASF_OP_CLEAR_FILE) begin
      flags_next = cur_status;
      flags_next[asf_pkg::ASF_Z_BIT] = 1'b1;
    end
    flags_next = flags_next & asf_pkg::ASF_IMPL_MASK;
  end

  // Status register; flag ops into status win over the data write
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      alu_flags_reg <= asf_pkg::ASF_ZERO;
    end else if (i_ce && i_valid && amode_ok) begin
      if (to_status && !flag_op) begin
        alu_flags_reg <= res_next & asf_pkg::ASF_IMPL_MASK;
      end else begin
        alu_flags_reg <= flags_next;
      end
    end
  end

  // Write-back port; suppressed whenever status is the target, for any op
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      result_reg <= asf_pkg::ASF_ZERO;
      result_we_reg <= 1'b0;
      result_addr_reg <= '0;
    end else if (i_ce) begin
      result_reg <= res_next;
      result_addr_reg <= i_dest_addr;
      result_we_reg <= i_valid && amode_ok && !to_status;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      amode_err_reg <= 1'b0;
    end else if (i_ce) begin
      amode_err_reg <= i_valid && !amode_ok;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_alu_flags <= asf_pkg::ASF_ZERO;
    end else if (i_ce) begin
      o_alu_flags <= alu_flags_reg & asf_pkg::ASF_IMPL_MASK;
    end
  end

  assign o_result = result_reg;
  assign o_result_we = result_we_reg;
  assign o_result_addr = result_addr_reg;
  assign o_amode_err = amode_err_reg;
endmodule
`default_nettype wire

// File: design/asf_pkg.sv
// Package for the ALU status flag block: opcodes, flag positions, modes
package asf_pkg;
  localparam int ASF_W = 8;
  localparam int ASF_NIB = 4;
  // Flag bit positions within the status register
  localparam int ASF_C_BIT = 0;
  localparam int ASF_DC_BIT = 1;
  localparam int ASF_Z_BIT = 2;
  localparam int ASF_OV_BIT = 3;
  localparam int ASF_N_BIT = 4;
  localparam int ASF_MSB = 7;
  localparam logic [7:0] ASF_IMPL_MASK = 8'h1f;
  localparam logic [7:0] ASF_ZERO = 8'h00;
  localparam logic [7:0] ASF_ONE = 8'h01;
  // Status register address in data memory, arbitrary default
  localparam logic [11:0] ASF_STATUS_ADDR = 12'hfd8;

  typedef enum logic [3:0] {
    ASF_OP_NONE,
    ASF_OP_ADD_ACC_FILE,
    ASF_OP_ADD_LITERAL,
    ASF_OP_SUB_FROM_LITERAL,
    ASF_OP_SUB_ACC_FROM_FILE,
    ASF_OP_ROTATE_LEFT,
    ASF_OP_ROTATE_RIGHT,
    ASF_OP_CLEAR_FILE,
    ASF_OP_AND,
    ASF_OP_OR,
    ASF_OP_XOR,
    ASF_OP_BIT_CLEAR,
    ASF_OP_BIT_SET,
    ASF_OP_NIBBLE_SWAP,
    ASF_OP_MOVE
  } asf_op_t;

  typedef enum logic [2:0] {
    ASF_AM_INHERENT,
    ASF_AM_LITERAL,
    ASF_AM_DIRECT,
    ASF_AM_INDIRECT,
    ASF_AM_INDEXED
  } asf_amode_t;
endpackage

// File: tb/asf_alu_flags_sva.sv
// Concurrent checks on the ALU status flag block ports
`timescale 1ns/1ps
`default_nettype none
module asf_alu_flags_sva (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire asf_pkg::asf_op_t i_op,
  input wire asf_pkg::asf_amode_t i_amode,
  input wire logic i_extended_set_enable,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_operand,
  input wire logic [11:0] i_dest_addr,
  input wire logic [7:0] o_result,
  input wire logic o_result_we,
  input wire logic [7:0] o_alu_flags,
  input wire logic o_amode_err
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic bad = i_amode == asf_pkg::ASF_AM_INDEXED && !i_extended_set_enable;
  wire logic tk = i_ce && i_valid;
  wire logic ok = tk && !bad;
  wire logic st = i_dest_addr == asf_pkg::ASF_STATUS_ADDR;
  // Output flag copy trails the result by one enabled edge
  sequence s_add;
    ok && !st && i_op == asf_pkg::ASF_OP_ADD_ACC_FILE ##1 i_ce;
  endsequence
  a_upper_bits_zero: assert property (o_alu_flags[7:5] == 3'h0)
    else $error("upper status bits set");
  a_status_no_write: assert property (ok && st |=> !o_result_we)
    else $error("result written to status");
  a_indexed_refused: assert property (tk && bad |=> o_amode_err && !o_result_we)
    else $error("indexed mode not refused");
  a_sub_result: assert property (ok && !st && i_op == asf_pkg::ASF_OP_SUB_ACC_FROM_FILE
    |=> o_result == $past(i_operand) - $past(i_acc)) else $error("subtract result wrong");
  a_neg_zero: assert property (s_add |=> o_alu_flags[4] == $past(o_result[7])
    && o_alu_flags[2] == ($past(o_result) == 8'h00)) else $error("negative or zero wrong");
  a_add_carry: assert property (s_add
    |=> o_alu_flags[0] == ($past(i_acc, 2) > ~$past(i_operand, 2))) else $error("carry wrong");
  a_rotate_carry: assert property (ok && i_op == asf_pkg::ASF_OP_ROTATE_LEFT ##1 i_ce
    |=> o_alu_flags[0] == $past(i_operand[7], 2)) else $error("rotate carry wrong");
  a_clear_zero: assert property (ok && i_op == asf_pkg::ASF_OP_CLEAR_FILE ##1 i_ce
    |=> o_alu_flags[2]) else $error("clear left zero flag low");
endmodule
bind asf_alu_flags asf_alu_flags_sva u_sva (
  .i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b),
  .i_ce(i_ce),
  .i_valid(i_valid),
  .i_op(i_op),
  .i_amode(i_amode),
  .i_extended_set_enable(i_extended_set_enable),
  .i_acc(i_acc),
  .i_operand(i_operand),
  .i_dest_addr(i_dest_addr),
  .o_result(o_result),
  .o_result_we(o_result_we),
  .o_alu_flags(o_alu_flags),
  .o_amode_err(o_amode_err)
);
`default_nettype wire

// File: tb/alu_status_flags_tb_top.sv
// Self-checking bench for the ALU status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got %h want %h", $time, a, e); end end
module alu_status_flags_tb_top;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic i_valid = 1'b0;
  logic i_extended_set_enable = 1'b0;
  logic o_result_we, o_amode_err;
  logic [2:0] i_bit_sel = 3'h2;
  logic [7:0] i_acc = 8'h00, i_operand = 8'h00, i_rd_data = 8'h00, o_result, o_alu_flags;
  logic [11:0] i_dest_addr = 12'h010, o_result_addr;
  asf_pkg::asf_op_t i_op = asf_pkg::ASF_OP_NONE;
  asf_pkg::asf_amode_t i_amode = asf_pkg::ASF_AM_DIRECT;
  int bad_count = 0, comparisons = 0, cycles = 0;
  asf_alu_flags dut (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_valid(i_valid),
    .i_op(i_op),
    .i_amode(i_amode),
    .i_extended_set_enable(i_extended_set_enable),
    .i_acc(i_acc),
    .i_operand(i_operand),
    .i_dest_addr(i_dest_addr),
    .i_bit_sel(i_bit_sel),
    .i_rd_data(i_rd_data),
    .o_result(o_result),
    .o_result_we(o_result_we),
    .o_result_addr(o_result_addr),
    .o_alu_flags(o_alu_flags),
    .o_amode_err(o_amode_err)
  );
  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 400) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One instruction, then result and flag copy a cycle apart
  task automatic run(asf_pkg::asf_op_t op, logic [7:0] a, b, logic [11:0] d, logic [7:0] r, f);
    logic err;
    logic we;
    @(negedge i_core_clk);
    err = i_amode == asf_pkg::ASF_AM_INDEXED && !i_extended_set_enable;
    we = !err && d != asf_pkg::ASF_STATUS_ADDR;
    i_op = op;
    i_acc = a;
    i_operand = b;
    i_dest_addr = d;
    i_valid = 1'b1;
    @(negedge i_core_clk);
    i_valid = 1'b0;
    `CHK(o_amode_err, err)
    `CHK(o_result_we, we)
    `CHK(o_result_addr, d)
    if (we) `CHK(o_result, r)
    @(negedge i_core_clk);
    `CHK(o_alu_flags, f)
  endtask
  initial begin
    repeat (10) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    // Status starts at zero, so refused and legal modes expect the same flags
    for (int m = 0; m < 5; m++) begin
      i_amode = asf_pkg::asf_amode_t'(m[2:0]);
      run(asf_pkg::ASF_OP_ADD_ACC_FILE, 8'h01, 8'h01, 12'h010, 8'h02, 8'h00);
    end
    i_extended_set_enable = 1'b1;
    run(asf_pkg::ASF_OP_ADD_ACC_FILE, 8'h01, 8'h01, 12'h010, 8'h02, 8'h00);
    i_amode = asf_pkg::ASF_AM_DIRECT;
    run(asf_pkg::ASF_OP_SUB_ACC_FROM_FILE, 8'h01, 8'h12, 12'h010, 8'h11, 8'h03);
    run(asf_pkg::ASF_OP_ADD_ACC_FILE, 8'h7f, 8'h01, 12'h010, 8'h80, 8'h1a);
    run(asf_pkg::ASF_OP_ADD_ACC_FILE, 8'hff, 8'h01, 12'h010, 8'h00, 8'h07);
    run(asf_pkg::ASF_OP_SUB_ACC_FROM_FILE, 8'h01, 8'h00, 12'h010, 8'hff, 8'h10);
    run(asf_pkg::ASF_OP_SUB_FROM_LITERAL, 8'h01, 8'h80, 12'h010, 8'h7f, 8'h09);
    run(asf_pkg::ASF_OP_ROTATE_LEFT, 8'h80, 8'h80, 12'h010, 8'h01, 8'h09);
    run(asf_pkg::ASF_OP_ROTATE_RIGHT, 8'h02, 8'h02, 12'h010, 8'h81, 8'h18);
    run(asf_pkg::ASF_OP_CLEAR_FILE, 8'h00, 8'h00, 12'hfd8, 8'h00, 8'h1c);
    run(asf_pkg::ASF_OP_BIT_CLEAR, 8'h00, 8'hff, 12'hfd8, 8'h00, 8'h1b);
    // Clock enable low: an offered instruction must leave no trace
    i_ce = 1'b0;
    i_op = asf_pkg::ASF_OP_ADD_ACC_FILE;
    i_acc = 8'hff;
    i_operand = 8'h01;
    i_dest_addr = 12'h010;
    i_valid = 1'b1;
    repeat (2) @(negedge i_core_clk);
    `CHK(o_alu_flags, 8'h1b)
    `CHK(o_result, 8'hfb)
    `CHK(o_result_we, 1'b0)
    i_valid = 1'b0;
    i_ce = 1'b1;
    i_rst_b = 1'b0;
    @(negedge i_core_clk);
    i_rst_b = 1'b1;
    `CHK(o_alu_flags, 8'h00)
    `CHK(o_result_we, 1'b0)
    // Remaining op codes bar NONE, plus a rotate into status; flags threaded from one to the next
    run(asf_pkg::ASF_OP_ADD_LITERAL, 8'h08, 8'h08, 12'h010, 8'h10, 8'h02);
    run(asf_pkg::ASF_OP_AND, 8'hf0, 8'h0f, 12'h010, 8'h00, 8'h06);
    run(asf_pkg::ASF_OP_OR, 8'h80, 8'h01, 12'h010, 8'h81, 8'h12);
    run(asf_pkg::ASF_OP_XOR, 8'hff, 8'hff, 12'hfd8, 8'h00, 8'h06);
    run(asf_pkg::ASF_OP_BIT_SET, 8'h00, 8'h00, 12'h010, 8'h04, 8'h06);
    run(asf_pkg::ASF_OP_NIBBLE_SWAP, 8'h00, 8'h3c, 12'hfd8, 8'hc3, 8'h03);
    run(asf_pkg::ASF_OP_MOVE, 8'h00, 8'h15, 12'h010, 8'h15, 8'h03);
    run(asf_pkg::ASF_OP_ROTATE_LEFT, 8'h00, 8'h40, 12'hfd8, 8'h81, 8'h12);
    report_and_stop();
  end
endmodule
`default_nettype wire
